// ==== include/mcd_consts.vh ====
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
// Register byte offsets
`define MCD_RD1 8'h00
`define MCD_RD2 8'h04
`define MCD_SH0 8'h08
`define MCD_SH1 8'h0c
`define MCD_CTRL 8'h10
`define MCD_PAIR 8'h14
`define MCD_SWIN 8'h18
`define MCD_SRCX 8'h20
`define MCD_SRCY 8'h24
`define MCD_SRCZ 8'h28
`define MCD_SRCW 8'h2c
`define MCD_DDST 8'h30
`define MCD_DBASE 8'h34
`define MCD_DSWAP 8'h38
`define MCD_LANE0 8'h40
`define MCD_LANE1 8'h44
`define MCD_LANE2 8'h48
`define MCD_LANE3 8'h4c
`define MCD_SHST 8'h50
`define MCD_RETA 8'h54
`define MCD_RETB 8'h58
`define MCD_TFIDX 8'h5c
`define MCD_TFLOD 8'h60
// Shared memory window, 128 words
`define MCD_MEM_AW 7
`define MCD_MEM_BASE 10'h200
// Control bits
`define MCD_CTRL_GO 0
`define MCD_CTRL_CLR 1
`define MCD_CTRL_SCR 2
`define MCD_CTRL_CONST 3
// Fixed codes
`define MCD_CLASS_MEM 5'h02
`define MCD_SUB_SHARED 3'h4
`define MCD_SUB_TESS 3'h5
`define MCD_MODE_LOOP 2'h1
`define MCD_MODE_GLOBAL 2'h2
`define MCD_ONE_F 32'h3f800000
`define MCD_RET_BASE 6'h20
`define MCD_RET_LAST 6'h33
`endif

// ==== tb/mcd_decoder_asserts.sv ====
`timescale 1ns/1ps
module mcd_decoder_asserts (
	// Bus
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	// Decode
	input wire [3:0] lane_write_en,
	input wire shared_mem_access,
	input wire tess_factor_write,
	input wire return_valid
);
	reg wr_q;
	reg [11:0] adr_q;
	reg [1:0] up_q;
	wire take = hsel & hready & htrans[1];
	wire go = wr_q & adr_q == 12'h010 & hwdata[0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			adr_q <= 12'h000;
			up_q <= 2'h0;
		end else begin
			wr_q <= take & hwrite;
			adr_q <= haddr;
			up_q <= {up_q[0], 1'b1};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_op_ret;
		go ##1 return_valid;
	endsequence
	a_ready_high: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("hresp set");
	a_ret_cause: assert property (return_valid |-> $past(go)) else $error("stray return");
	a_ret_single: assert property (s_op_ret |=> !return_valid) else $error("long return");
	a_kind_excl: assert property (!(shared_mem_access && tess_factor_write)) else $error("both kinds");
	a_lane_hold: assert property (up_q[1] && $changed(lane_write_en) |-> $past(wr_q) || $past(wr_q, 2))
		else $error("lanes moved");
	a_kind_hold: assert property (up_q[1] && $changed({shared_mem_access, tess_factor_write})
		|-> $past(wr_q) || $past(wr_q, 2)) else $error("kind moved");
	a_rdata_hold: assert property (up_q[1] && $changed(hrdata) |-> $past(take && !hwrite)) else $error("rdata moved");
endmodule
bind mcd_decoder mcd_decoder_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .lane_write_en(lane_write_en), .shared_mem_access(shared_mem_access),
	.tess_factor_write(tess_factor_write), .return_valid(return_valid));

// ==== tb/mcd_decoder_tb.sv ====
`timescale 1ns/1ps
module mcd_decoder_tb;
	reg hclk, hresetn, hsel, hwrite, step, tess, ret;
	reg [1:0] htrans, dm, rc;
	reg [11:0] haddr;
	reg [8:0] src_field;
	reg [31:0] hwdata, st, rd, w, s, z;
	reg [6:0] a, t, di, si;
	reg [5:0] op;
	wire hreadyout, hresp, shared_mem_access, tess_factor_write, return_valid;
	wire [31:0] hrdata, sh0_word;
	wire [6:0] loop_index, dest_reg_index;
	wire [3:0] lane_write_en;
	integer failures, comparisons, k, n;
	mcd_decoder uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .loop_index(loop_index), .dest_reg_index(dest_reg_index),
		.lane_write_en(lane_write_en), .shared_mem_access(shared_mem_access),
		.tess_factor_write(tess_factor_write), .return_valid(return_valid));
	mcd_seq_model sq (.hclk(hclk), .hresetn(hresetn), .step(step), .tess(tess), .src_field(src_field),
		.loop_index(loop_index), .sh0_word(sh0_word));
	initial begin
		hclk = 0;
		forever #2.5 hclk = ~hclk;
	end
	////////////////////////////////////////
	function [31:0] xs(input [31:0] x);
		begin
			x = x ^ x << 13;
			x = x ^ x >> 17;
			xs = x ^ x << 5;
		end
	endfunction
	function [31:0] dd(input [31:0] r);
		dd = {6'h0, r[31:22], 4'h0, ~&r[20:19], ~&r[17:16], ~&r[14:13], ~&r[11:10], 1'b0,
			r[6:0] + (r[7] ? loop_index : 7'h0)};
	endfunction
	function [31:0] eop(input [4:0] b, input [31:0] w, s, z);
		case (b)
			0: eop = w + s;
			1: eop = w - s;
			2: eop = s - w;
			3: eop = w >= s ? 0 : w + 1;
			4: eop = (w == 0 || w > s) ? s : w - 1;
			5: eop = $signed(w) < $signed(s) ? w : s;
			6: eop = $signed(w) > $signed(s) ? w : s;
			7: eop = w < s ? w : s;
			8: eop = w > s ? w : s;
			9: eop = w & s;
			10: eop = w | s;
			11: eop = w ^ s;
			12: eop = w & ~s | z;
			13, 14, 15: eop = s;
			16, 17: eop = w == s ? z : w;
			18: eop = s & 32'hff;
			19: eop = s & 32'hffff;
			default: eop = w;
		endcase
	endfunction
	task end_sim;
		begin
			if (failures == 0 && comparisons > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input [31:0] e, input [31:0] g, input [47:0] nm);
		begin
			comparisons++;
			if (g !== e) begin
				failures++;
				$display("ERROR %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wt;
		begin
			n = 0;
			@(posedge hclk);
			while (hreadyout !== 1'b1) begin
				n++;
				if (n > 50) begin
					failures++;
					end_sim;
				end
				@(posedge hclk);
			end
		end
	endtask
	task bus(input wr, input [11:0] ad, input [31:0] d);
		begin
			hsel <= 1;
			htrans <= 2'h2;
			haddr <= ad;
			hwrite <= wr;
			wt;
			hsel <= 0;
			htrans <= 0;
			hwdata <= d;
			wt;
			rd = hrdata;
		end
	endtask
	task stp;
		begin
			step <= 1;
			@(posedge hclk);
			step <= 0;
		end
	endtask
	////////////////////////////////////////
	initial begin
		{hresetn, hsel, hwrite, step, tess, htrans, haddr, src_field, hwdata} = 0;
		failures = 0;
		comparisons = 0;
		st = 49751;
		repeat (16) @(posedge hclk);
		hresetn <= 1;
		bus(0, 12'h0fc, 0);
		chk(0, rd, "unmap");
		for (k = 0; k < 8; k++) begin
			stp;
			st = xs(st);
			if (k[0])
				st[9 + 3 * (k % 4) +: 3] = 3'h5;
			bus(1, 12'h000, st);
			bus(1, 12'h004, st);
			bus(0, 12'h030, 0);
			chk(dd(st), rd, "rdword");
			chk(dd(st) >> 8 & 15, lane_write_en, "lanes");
			chk(dd(st) & 127, dest_reg_index, "dest");
			bus(0, 12'h040 | (k % 4) << 2, 0);
			chk(st[9 + 3 * (k % 4) +: 3] == 5 ? 32'h3f800000 : 0, rd, "lane");
			bus(1, 12'h010, k << 2 & 12);
			bus(0, 12'h034, 0);
			chk({k[1] ? 2'h0 : st[17:16], k[0] ? {st[12:0], 2'h0} : {2'h0, st[12:0]}}, rd & 32'h1ffff, "base");
			chk(k[0] ? st[31:20] : 0, rd >> 18, "size");
		end
		for (k = 0; k < 40; k++) begin
			stp;
			op = k < 20 ? k : k + 12;
			st = xs(st);
			w = st;
			st = xs(st);
			s = k % 3 ? st : w;
			st = xs(st);
			z = st;
			a = st[6:0];
			dm = st[8:7] == 3 ? 2 : st[8:7];
			src_field <= {dm, st[23:17]};
			bus(1, 12'h200 | a << 2, w);
			bus(1, 12'h020, a);
			bus(1, 12'h024, s);
			bus(1, 12'h028, z);
			bus(1, 12'h008, sh0_word);
			bus(1, 12'h00c, {op, dm, st[30:24]});
			bus(1, 12'h014, 1);
			bus(1, 12'h010, 1);
			bus(0, 12'h200 | a << 2, 0);
			chk(eop(op[4:0], w, s, z), rd, "mem");
			if (op[4:1] == 7) begin
				t = a + (op[0] ? 64 : 1);
				bus(0, 12'h200 | t << 2, 0);
				chk(z, rd, "pair");
			end
			ret = op[5];
			di = st[30:24] + (dm == 1 ? loop_index : 0);
			si = st[23:17] + (dm == 1 ? loop_index : 0);
			if (ret) begin
				bus(0, 12'h054, 0);
				chk(w, rd, "reta");
				chk(di, dest_reg_index, "rdest");
			end
			bus(0, 12'h050, 0);
			rc = ret ? (op[4:1] == 7 ? 2'h2 : 2'h1) : 2'h0;
			chk({2'h0, dm == 2, dm == 2, rc, 3'h1, ret, op, 1'b0, di, 1'b0, si}, rd, "stat");
		end
		bus(1, 12'h008, sh0_word ^ 1);
		bus(1, 12'h010, 1);
		bus(0, 12'h050, 0);
		chk(1, rd[25], "err");
		bus(0, 12'h200 | a << 2, 0);
		chk(eop(op[4:0], w, s, z), rd, "keep");
		tess <= 1;
		bus(1, 12'h010, 2);
		bus(1, 12'h008, sh0_word);
		bus(1, 12'h010, 1);
		chk(1, {shared_mem_access, tess_factor_write}, "kind");
		bus(0, 12'h05c, 0);
		chk(a, rd, "tfidx");
		bus(0, 12'h060, 0);
		chk(s, rd, "tflod");
		bus(0, 12'h050, 0);
		chk(0, rd[25], "eclr");
		end_sim;
	end
endmodule

// ==== tb/mcd_seq_model.sv ====
`timescale 1ns/1ps
module mcd_seq_model (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// Bench requests
	input wire step,
	input wire tess,
	input wire [8:0] src_field,
	// Toward the decoder
	output reg [6:0] loop_index,
	output wire [31:0] sh0_word
);
	// Class 2, sub-op 4 or 5, selectors X Y Z
	assign sh0_word = {3'h0, 3'h2, 3'h1, 3'h0, src_field, 2'h2, tess, 3'h0, 5'h02};
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			loop_index <= 7'h00;
		else if (step)
			loop_index <= loop_index + 7'h01;
	end
endmodule

// ==== verilog/mcd_decoder.v ====
`timescale 1ns/1ps
`include "mcd_consts.vh"
module mcd_decoder (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	// Loop index from sequencer
	input wire [6:0] loop_index,
	// Decoded results
	output reg [6:0] dest_reg_index,
	output reg [3:0] lane_write_en,
	output reg shared_mem_access,
	output reg tess_factor_write,
	output reg return_valid
);

function [31:0] comp_sel;
	input [2:0] code;
	input [31:0] x;
	input [31:0] y;
	input [31:0] z;
	input [31:0] w;
	begin
		case (code)
			3'h0: comp_sel = x;
			3'h1: comp_sel = y;
			3'h2: comp_sel = z;
			3'h3: comp_sel = w;
			3'h5: comp_sel = `MCD_ONE_F;
			default: comp_sel = 32'h00000000;
		endcase
	end
endfunction

function [6:0] idx_mode;
	input [6:0] idx;
	input [1:0] mode;
	input [6:0] loop;
	begin
		if (mode == `MCD_MODE_LOOP) begin
			idx_mode = idx + loop;
		end else begin
			idx_mode = idx;
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// Software registers
reg [31:0] rd1_q;
reg [31:0] rd2_q;
reg [31:0] sh0_q;
reg [31:0] sh1_q;
reg [3:0] ctrl_q;
reg [6:0] pair_q;
reg [31:0] swin_q;
reg [31:0] src_q [0:3];
reg err_q;
reg [31:0] reta_q;
reg [31:0] retb_q;
reg [31:0] tfidx_q;
reg [31:0] tflod_q;
reg [1:0] retcnt_q;
reg [31:0] mem_q [0:127];

// AHB address phase capture
reg wr_q;
reg [11:0] waddr_q;
wire acc = hsel & hready & htrans[1];

// Zero wait states, always OKAY
assign hreadyout = 1'b1;
assign hresp = 1'b0;

////////////////////////////////////////////////////////////////////////
// Memory-read word decode
wire [6:0] rd_dst = rd1_q[7] ? rd1_q[6:0] + loop_index : rd1_q[6:0];
wire [5:0] elem_layout = rd1_q[27:22];
wire [1:0] num_interp = rd1_q[29:28];
wire comp_signed = rd1_q[30];
wire signed_fraction_mapping = rd1_q[31];
wire [14:0] base_dw = ctrl_q[`MCD_CTRL_SCR] ? {rd2_q[12:0], 2'b00} : {2'b00, rd2_q[12:0]};
wire [1:0] swap_mode = ctrl_q[`MCD_CTRL_CONST] ? 2'b00 : rd2_q[17:16];
wire [1:0] elem_code = sh0_q[6:5];
reg [13:0] size_dw;
reg [31:0] swapped;

always @* begin
	size_dw = 14'h0000;
	if (ctrl_q[`MCD_CTRL_SCR]) begin
		case (elem_code)
			2'h0: size_dw = {2'b00, rd2_q[31:20]};
			2'h3: size_dw = {rd2_q[31:20], 2'b00};
			default: size_dw = {1'b0, rd2_q[31:20], 1'b0};
		endcase
	end
	case (swap_mode)
		2'h1: swapped = {swin_q[23:16], swin_q[31:24], swin_q[7:0], swin_q[15:8]};
		2'h2: swapped = {swin_q[7:0], swin_q[15:8], swin_q[23:16], swin_q[31:24]};
		default: swapped = swin_q;
	endcase
end

// Per-lane result select
wire [31:0] lane_val [0:3];
wire [3:0] lane_en_d;
genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
		wire [2:0] sel = rd1_q[9 + 3 * gi +: 3];
		assign lane_val[gi] = comp_sel(sel, src_q[0], src_q[1], src_q[2], src_q[3]);
		// Reserved code 6 masks like code 7
		assign lane_en_d[gi] = (sel != 3'h7) && (sel != 3'h6);
	end
endgenerate

// One register holds all lane enables
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		lane_write_en <= 4'h0;
	end else begin
		lane_write_en <= lane_en_d;
	end
end

////////////////////////////////////////////////////////////////////////
// Shared-memory word decode
wire class_ok = sh0_q[4:0] == `MCD_CLASS_MEM;
wire [2:0] sub_op = sh0_q[10:8];
wire is_shared = class_ok && sub_op == `MCD_SUB_SHARED;
wire is_tess = class_ok && sub_op == `MCD_SUB_TESS;
wire [1:0] src_mode = sh0_q[19:18];
wire [6:0] src_idx = idx_mode(sh0_q[17:11], src_mode, loop_index);
wire [31:0] c0 = comp_sel(sh0_q[22:20], src_q[0], src_q[1], src_q[2], src_q[3]);
wire [31:0] c1 = comp_sel(sh0_q[25:23], src_q[0], src_q[1], src_q[2], src_q[3]);
wire [31:0] c2 = comp_sel(sh0_q[28:26], src_q[0], src_q[1], src_q[2], src_q[3]);
wire [1:0] dst_mode = sh1_q[8:7];
wire [6:0] sh_dst = idx_mode(sh1_q[6:0], dst_mode, loop_index);
wire [5:0] op_code = sh1_q[14:9];
// Returning codes reuse the plain update
wire op_ret = op_code >= `MCD_RET_BASE && op_code <= `MCD_RET_LAST;
wire [5:0] base_op = op_ret ? op_code - `MCD_RET_BASE : op_code;
wire [6:0] addr_a = c0[6:0];
reg [6:0] addr_b;
reg [31:0] old_a;
reg [31:0] new_a;
reg upd_a;
reg upd_b;

always @* begin
	old_a = mem_q[addr_a];
	new_a = old_a;
	upd_a = 1'b1;
	upd_b = 1'b0;
	addr_b = addr_a + pair_q;
	case (base_op)
		6'd0: new_a = old_a + c1;
		6'd1: new_a = old_a - c1;
		6'd2: new_a = c1 - old_a;
		6'd3: new_a = (old_a >= c1) ? 32'h00000000 : old_a + 32'h00000001;
		6'd4: new_a = (old_a == 32'h00000000 || old_a > c1) ? c1 : old_a - 32'h00000001;
		6'd5: new_a = ($signed(old_a) < $signed(c1)) ? old_a : c1;
		6'd6: new_a = ($signed(old_a) > $signed(c1)) ? old_a : c1;
		6'd7: new_a = (old_a < c1) ? old_a : c1;
		6'd8: new_a = (old_a > c1) ? old_a : c1;
		6'd9: new_a = old_a & c1;
		6'd10: new_a = old_a | c1;
		6'd11: new_a = old_a ^ c1;
		6'd12: new_a = (old_a & ~c1) | c2;
		6'd13: new_a = c1;
		6'd14: begin
			new_a = c1;
			upd_b = 1'b1;
		end
		6'd15: begin
			new_a = c1;
			addr_b = addr_a + {pair_q[0], 6'h00};
			upd_b = 1'b1;
		end
		6'd16, 6'd17: new_a = (old_a == c1) ? c2 : old_a;
		6'd18: new_a = {24'h000000, c1[7:0]};
		6'd19: new_a = {16'h0000, c1[15:0]};
		default: upd_a = 1'b0;
	endcase
end

////////////////////////////////////////////////////////////////////////
// Bus write and execution
wire wr_now = wr_q;
wire wr_ctrl = wr_now && waddr_q[7:0] == `MCD_CTRL && waddr_q[11:8] == 4'h0;
wire go = wr_ctrl && hwdata[`MCD_CTRL_GO];
// Shared word window at 0x200 to 0x3FF
wire wr_mem = wr_now && waddr_q[11:9] == 3'b001;
integer i;
integer j;

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		wr_q <= 1'b0;
		waddr_q <= 12'h000;
	end else if (hready) begin
		wr_q <= acc && hwrite;
		waddr_q <= haddr;
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		rd1_q <= 32'h00000000;
		rd2_q <= 32'h00000000;
		sh0_q <= 32'h00000000;
		sh1_q <= 32'h00000000;
		ctrl_q <= 4'h0;
		pair_q <= 7'h00;
		swin_q <= 32'h00000000;
		for (i = 0; i < 4; i = i + 1) begin
			src_q[i] <= 32'h00000000;
		end
	end else if (wr_now && waddr_q[11:8] == 4'h0) begin
		case (waddr_q[7:0])
			`MCD_RD1: rd1_q <= hwdata;
			`MCD_RD2: rd2_q <= hwdata;
			`MCD_SH0: sh0_q <= hwdata;
			`MCD_SH1: sh1_q <= hwdata;
			`MCD_CTRL: ctrl_q <= {hwdata[3:2], 2'b00};
			`MCD_PAIR: pair_q <= hwdata[6:0];
			`MCD_SWIN: swin_q <= hwdata;
			`MCD_SRCX: src_q[0] <= hwdata;
			`MCD_SRCY: src_q[1] <= hwdata;
			`MCD_SRCZ: src_q[2] <= hwdata;
			`MCD_SRCW: src_q[3] <= hwdata;
			default: ;
		endcase
	end
end

// Shared memory and operation results
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		for (j = 0; j < 128; j = j + 1) begin
			mem_q[j] <= 32'h00000000;
		end
		reta_q <= 32'h00000000;
		retb_q <= 32'h00000000;
		tfidx_q <= 32'h00000000;
		tflod_q <= 32'h00000000;
		retcnt_q <= 2'h0;
		err_q <= 1'b0;
		return_valid <= 1'b0;
		dest_reg_index <= 7'h00;
	end else begin
		return_valid <= 1'b0;
		if (wr_mem) begin
			mem_q[waddr_q[8:2]] <= hwdata;
		end
		if (go && !(is_shared || is_tess)) begin
			err_q <= 1'b1;
		end else if (wr_ctrl && hwdata[`MCD_CTRL_CLR]) begin
			err_q <= 1'b0;
		end
		dest_reg_index <= (is_shared && op_ret) ? sh_dst : rd_dst;
		if (go && is_tess) begin
			tfidx_q <= src_q[0];
			tflod_q <= src_q[1];
		end
		if (go && is_shared) begin
			if (upd_a) begin
				mem_q[addr_a] <= new_a;
			end
			if (upd_b) begin
				mem_q[addr_b] <= c2;
			end
			if (op_ret) begin
				reta_q <= old_a;
				retb_q <= upd_b ? mem_q[addr_b] : 32'h00000000;
				retcnt_q <= upd_b ? 2'h2 : 2'h1;
				return_valid <= 1'b1;
			end else begin
				retcnt_q <= 2'h0;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// Read mux, registered in the address phase
reg [31:0] rmux;

always @* begin
	rmux = 32'h00000000;
	if (haddr[11:9] == 3'b001) begin
		rmux = mem_q[haddr[8:2]];
	end else if (haddr[11:8] == 4'h0) begin
		case (haddr[7:0])
			`MCD_RD1: rmux = rd1_q;
			`MCD_RD2: rmux = rd2_q;
			`MCD_SH0: rmux = sh0_q;
			`MCD_SH1: rmux = sh1_q;
			`MCD_CTRL: rmux = {28'h0000000, ctrl_q};
			`MCD_PAIR: rmux = {25'h0000000, pair_q};
			`MCD_SWIN: rmux = swin_q;
			`MCD_SRCX: rmux = src_q[0];
			`MCD_SRCY: rmux = src_q[1];
			`MCD_SRCZ: rmux = src_q[2];
			`MCD_SRCW: rmux = src_q[3];
			`MCD_DDST: rmux = {6'h00, signed_fraction_mapping, comp_signed, num_interp, elem_layout,
				4'h0, lane_write_en, 1'b0, rd_dst};
			`MCD_DBASE: rmux = {size_dw, 1'b0, swap_mode, base_dw};
			`MCD_DSWAP: rmux = swapped;
			`MCD_LANE0: rmux = lane_val[0];
			`MCD_LANE1: rmux = lane_val[1];
			`MCD_LANE2: rmux = lane_val[2];
			`MCD_LANE3: rmux = lane_val[3];
			`MCD_SHST: rmux = {2'b00, src_mode == `MCD_MODE_GLOBAL, dst_mode == `MCD_MODE_GLOBAL,
				retcnt_q, err_q, is_tess, is_shared, op_ret, op_code, 1'b0, sh_dst, 1'b0, src_idx};
			`MCD_RETA: rmux = reta_q;
			`MCD_RETB: rmux = retb_q;
			`MCD_TFIDX: rmux = tfidx_q;
			`MCD_TFLOD: rmux = tflod_q;
			default: rmux = 32'h00000000;
		endcase
	end
end

always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
		shared_mem_access <= 1'b0;
		tess_factor_write <= 1'b0;
	end else begin
		if (acc && !hwrite) begin
			hrdata <= rmux;
		end
		shared_mem_access <= is_shared;
		tess_factor_write <= is_tess;
	end
end

endmodule
